// ---- logic/dms_top.sv ----
// The register addresses and strobed register access were chosen for this implementation.
`default_nettype none
module dms_top
  import dms_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWe,
  input  wire logic              regRe,
  output var  logic [DATA_W-1:0] regRdata,
  input  wire logic              powerDownPinN,
  input  wire logic              parallelMode,
  input  wire logic              serialBitClock,
  input  wire logic              frameClock,
  input  wire logic              serialAudioIn,
  input  wire logic              dsdBitClock,
  input  wire logic              dsdLeftIn,
  input  wire logic              dsdRightIn,
  output var  logic              coreRun,
  output var  logic              dsdActive,
  output var  logic [2:0]        speedEff,
  output var  logic              ratioOk,
  output var  logic              dataBitClock,
  output var  logic              dataFrame,
  output var  logic              dataLeft,
  output var  logic              dataRight
);

  logic [NUM_PINS-1:0] pinRaw;
  logic [NUM_PINS-1:0] pinSync;
  logic                pdnLevel;
  logic                pdnActive;
  logic                hardRst;

  assign pinRaw[PIN_BCK] = serialBitClock;
  assign pinRaw[PIN_FRM] = frameClock;
  assign pinRaw[PIN_SDI] = serialAudioIn;
  assign pinRaw[PIN_DCK] = dsdBitClock;
  assign pinRaw[PIN_DSL] = dsdLeftIn;
  assign pinRaw[PIN_DSR] = dsdRightIn;
  assign pinRaw[PIN_PAR] = parallelMode;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      dms_sync3 #(
        .RESET_VAL (1'b0)
      ) u_sync (
        .clk  (clk),
        .srst (srst),
        .din  (pinRaw[gi]),
        .dout (pinSync[gi])
      );
    end
  endgenerate

  dms_sync3 #(
    .RESET_VAL (1'b1)
  ) u_pdn_sync (
    .clk  (clk),
    .srst (srst),
    .din  (powerDownPinN),
    .dout (pdnLevel)
  );

  dms_pdn_filter u_pdn_filter (
    .clk       (clk),
    .srst      (srst),
    .pinLevel  (pdnLevel),
    .pdnActive (pdnActive)
  );

  // pin low resets
  // every register below also returns to its reset value on accepted power-down
  assign hardRst = srst || pdnActive;

  // ---- register file ----
  logic       runBit_r;
  logic       autoBit_r;
  logic       ifSelBit_r;
  logic [2:0] speedCode_r;
  logic       wrCtrl;
  logic       wrSpeed;

  assign wrCtrl  = regWe && (regAddr == ADDR_CTRL);
  assign wrSpeed = regWe && (regAddr == ADDR_SPEED);

  // manual after release
  // auto bit returns to 0 whenever power-down is taken
  always_ff @(posedge clk) begin
    if (hardRst) begin
      runBit_r   <= CTRL_RESET[CTRL_RUN_BIT];
      autoBit_r  <= CTRL_RESET[CTRL_AUTO_BIT];
      ifSelBit_r <= CTRL_RESET[CTRL_IFSEL_BIT];
    end else if (wrCtrl) begin
      runBit_r   <= regWdata[CTRL_RUN_BIT];
      autoBit_r  <= regWdata[CTRL_AUTO_BIT];
      ifSelBit_r <= regWdata[CTRL_IFSEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (hardRst) begin
      speedCode_r <= SPEED_RESET;
    end else if (wrSpeed) begin
      speedCode_r <= regWdata[2:0];
    end
  end

  // ---- frame period measurement in master clock cycles ----
  logic               frPrev_r;
  logic               frRise;
  logic [RATIO_W-1:0] periodCnt_r;
  logic [RATIO_W-1:0] ratio_r;

  assign frRise = pinSync[PIN_FRM] && !frPrev_r;

  always_ff @(posedge clk) begin
    if (hardRst) begin
      frPrev_r <= 1'b0;
    end else begin
      frPrev_r <= pinSync[PIN_FRM];
    end
  end

  // ratio self-detected
  // a stopped frame clock saturates and reads as out of range
  always_ff @(posedge clk) begin
    if (hardRst) begin
      periodCnt_r <= '0;
      ratio_r     <= RATIO_SAT;
    end else if (frRise) begin
      periodCnt_r <= RATIO_W'(1);
      ratio_r     <= periodCnt_r;
    end else if (periodCnt_r != RATIO_SAT) begin
      periodCnt_r <= periodCnt_r + 1'b1;
    end else begin
      ratio_r     <= RATIO_SAT;
    end
  end

  // ---- sample-rate tick from the measured period ----
  logic [RATIO_W-1:0] fsTimer_r;
  logic               fsTick;

  assign fsTick = (fsTimer_r == '0);

  always_ff @(posedge clk) begin
    if (hardRst) begin
      fsTimer_r <= RATIO_SAT;
    end else if (fsTick) begin
      fsTimer_r <= ratio_r - 1'b1;
    end else begin
      fsTimer_r <= fsTimer_r - 1'b1;
    end
  end

  // ---- speed selection ----
  logic [2:0] autoSpeed;

  always_comb begin
    if (ratio_r >= AUTO_NORM_MIN) begin
      autoSpeed = SPD_NORMAL;
    end else if (ratio_r >= AUTO_DBL_MIN) begin
      autoSpeed = SPD_DOUBLE;
    end else if (ratio_r >= AUTO_QUAD_MIN) begin
      autoSpeed = SPD_QUAD;
    end else if (ratio_r >= AUTO_OCT_MIN) begin
      autoSpeed = SPD_OCT;
    end else begin
      autoSpeed = SPD_HEX;
    end
  end

  always_ff @(posedge clk) begin
    if (hardRst) begin
      speedEff <= SPD_NORMAL;
    end else if (autoBit_r) begin
      speedEff <= autoSpeed;
    end else begin
      unique case (speedCode_r)
        3'b000:  speedEff <= SPD_NORMAL;
        3'b001:  speedEff <= SPD_DOUBLE;
        3'b010:  speedEff <= SPD_QUAD;
        3'b011:  speedEff <= speedEff;
        3'b100:  speedEff <= SPD_OCT;
        3'b101:  speedEff <= SPD_HEX;
        3'b110:  speedEff <= SPD_OCT;
        3'b111:  speedEff <= SPD_HEX;
      endcase
    end
  end

  // ---- ratio range check against current speed ----
  logic ratioInRange;

  always_comb begin
    ratioInRange = 1'b0;
    case (speedEff)
      SPD_NORMAL: ratioInRange = (ratio_r >= NORMAL_MIN) && (ratio_r <= NORMAL_MAX);
      SPD_DOUBLE: ratioInRange = (ratio_r >= DOUBLE_MIN) && (ratio_r <= DOUBLE_MAX);
      SPD_QUAD:   ratioInRange = (ratio_r == QUAD_LO) || (ratio_r == QUAD_HI);
      SPD_OCT:    ratioInRange = (ratio_r >= OCT_MIN) && (ratio_r <= OCT_MAX);
      SPD_HEX:    ratioInRange = (ratio_r >= HEX_MIN) && (ratio_r <= HEX_MAX);
      default:    ratioInRange = 1'b0;
    endcase
  end

  // dsd carries no frame clock, so the check only means something in pcm
  always_ff @(posedge clk) begin
    if (hardRst) begin
      ratioOk <= 1'b0;
    end else begin
      ratioOk <= ratioInRange && !dsdActive;
    end
  end

  // ---- interface changeover ----
  dms_state_e state_r;
  logic [1:0] tickCnt_r;
  logic       ifReq;
  logic       startSwitch;

  assign ifReq = ifSelBit_r && !pinSync[PIN_PAR];

  assign startSwitch = ((state_r == ST_HOLD) && runBit_r)
                    || ((state_r == ST_RUN) && runBit_r && (ifReq != dsdActive));

  // two to three fs
  // ticks are free running, so three ticks span two to three periods
  always_ff @(posedge clk) begin
    if (hardRst) begin
      state_r <= ST_HOLD;
    end else if (!runBit_r) begin
      state_r <= ST_HOLD;
    end else begin
      unique case (state_r)
        ST_HOLD: begin
          state_r <= ST_SWITCH;
        end
        ST_SWITCH: begin
          if (fsTick && (tickCnt_r == 2'(SWITCH_FS_TICKS - 1))) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (ifReq != dsdActive) begin
            state_r <= ST_SWITCH;
          end
        end
        default: begin
          state_r <= ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (hardRst) begin
      tickCnt_r <= '0;
    end else if (startSwitch) begin
      tickCnt_r <= '0;
    end else if ((state_r == ST_SWITCH) && fsTick) begin
      tickCnt_r <= tickCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (hardRst) begin
      dsdActive <= 1'b0;
    end else if (startSwitch) begin
      dsdActive <= ifReq;
    end
  end

  always_ff @(posedge clk) begin
    if (hardRst) begin
      coreRun <= 1'b0;
    end else begin
      coreRun <= (state_r == ST_RUN) && runBit_r && (ifReq == dsdActive);
    end
  end

  // ---- data source routing ----
  // pin set per mode
  // master clock domain
  // outputs sit at zero outside run to keep the datapath quiet
  always_ff @(posedge clk) begin
    if (hardRst || !coreRun) begin
      dataBitClock <= 1'b0;
      dataFrame    <= 1'b0;
      dataLeft     <= 1'b0;
      dataRight    <= 1'b0;
    end else if (dsdActive) begin
      dataBitClock <= pinSync[PIN_DCK];
      dataFrame    <= 1'b0;
      dataLeft     <= pinSync[PIN_DSL];
      dataRight    <= pinSync[PIN_DSR];
    end else begin
      dataBitClock <= pinSync[PIN_BCK];
      dataFrame    <= pinSync[PIN_FRM];
      dataLeft     <= pinSync[PIN_SDI];
      dataRight    <= 1'b0;
    end
  end

  // ---- register read port ----
  logic [DATA_W-1:0] statusWord;

  always_comb begin
    statusWord = '0;
    statusWord[STAT_RUN_BIT]   = coreRun;
    statusWord[STAT_DSD_BIT]   = dsdActive;
    statusWord[STAT_AUTO_BIT]  = autoBit_r;
    statusWord[STAT_RATIO_BIT] = ratioOk;
    statusWord[STAT_SPD_LSB +: 3] = speedEff;
  end

  // unmapped addresses read as zero; no read side effects
  always_ff @(posedge clk) begin
    if (hardRst) begin
      regRdata <= '0;
    end else if (regRe) begin
      case (regAddr)
        ADDR_CTRL:     regRdata <= {5'h00, ifSelBit_r, autoBit_r, runBit_r};
        ADDR_SPEED:    regRdata <= {5'h00, speedCode_r};
        ADDR_STATUS:   regRdata <= statusWord;
        ADDR_RATIO_LO: regRdata <= ratio_r[7:0];
        ADDR_RATIO_HI: regRdata <= {4'h0, ratio_r[11:8]};
        default:       regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

endmodule // dms_top
`default_nettype wire

// ---- logic/dms_pkg.sv ----
`default_nettype none
package dms_pkg;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int PDN_ACCEPT_NS  = 150;
  localparam int PDN_REJECT_NS  = 30;
  localparam int PDN_ACCEPT_CYC = (PDN_ACCEPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PDN_REJECT_CYC = PDN_REJECT_NS / CLK_PERIOD_NS;
  localparam int PDN_THRESH_CYC = (PDN_ACCEPT_CYC + PDN_REJECT_CYC) / 2;
  localparam int PDN_CNT_W      = 6;

  localparam int SWITCH_FS_TICKS = 3;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_SPEED    = 4'h1;
  localparam logic [3:0] ADDR_STATUS   = 4'h2;
  localparam logic [3:0] ADDR_RATIO_LO = 4'h3;
  localparam logic [3:0] ADDR_RATIO_HI = 4'h4;

  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_AUTO_BIT  = 1;
  localparam int CTRL_IFSEL_BIT = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h1;
  localparam logic [2:0] SPEED_RESET = 3'h0;

  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_DSD_BIT   = 1;
  localparam int STAT_AUTO_BIT  = 2;
  localparam int STAT_RATIO_BIT = 3;
  localparam int STAT_SPD_LSB   = 4;

  typedef enum logic [2:0] {
    SPD_NORMAL = 3'b000,
    SPD_DOUBLE = 3'b001,
    SPD_QUAD   = 3'b010,
    SPD_OCT    = 3'b100,
    SPD_HEX    = 3'b101
  } dms_speed_e;

  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_SWITCH = 2'b01,
    ST_RUN    = 2'b10
  } dms_state_e;

  localparam int RATIO_W = 12;
  localparam logic [11:0] RATIO_SAT      = 12'hfff;
  localparam logic [11:0] NORMAL_MIN     = 12'h100;
  localparam logic [11:0] NORMAL_MAX     = 12'h480;
  localparam logic [11:0] DOUBLE_MIN     = 12'h100;
  localparam logic [11:0] DOUBLE_MAX     = 12'h200;
  localparam logic [11:0] QUAD_LO        = 12'h0c0;
  localparam logic [11:0] QUAD_HI        = 12'h100;
  localparam logic [11:0] OCT_MIN        = 12'h020;
  localparam logic [11:0] OCT_MAX        = 12'h080;
  localparam logic [11:0] HEX_MIN        = 12'h010;
  localparam logic [11:0] HEX_MAX        = 12'h040;
  localparam logic [11:0] AUTO_NORM_MIN  = 12'h200;
  localparam logic [11:0] AUTO_DBL_MIN   = 12'h100;
  localparam logic [11:0] AUTO_QUAD_MIN  = 12'h080;
  localparam logic [11:0] AUTO_OCT_MIN   = 12'h040;

  localparam int NUM_PINS = 7;
  localparam int PIN_BCK  = 0;
  localparam int PIN_FRM  = 1;
  localparam int PIN_SDI  = 2;
  localparam int PIN_DCK  = 3;
  localparam int PIN_DSL  = 4;
  localparam int PIN_DSR  = 5;
  localparam int PIN_PAR  = 6;
endpackage
`default_nettype wire

// ---- logic/dms_sync3.sv ----
`default_nettype none
module dms_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output var  logic dout
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      dout <= RESET_VAL;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule // dms_sync3
`default_nettype wire

// ---- logic/dms_pdn_filter.sv ----
`default_nettype none
module dms_pdn_filter
  import dms_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pinLevel,
  output var  logic pdnActive
);
  logic [PDN_CNT_W-1:0] lowCnt_r;
  localparam logic [PDN_CNT_W-1:0] THRESH = PDN_CNT_W'(PDN_THRESH_CYC);

  always_ff @(posedge clk) begin
    if (srst) begin
      lowCnt_r <= '0;
    end else if (pinLevel) begin
      lowCnt_r <= '0;
    end else if (lowCnt_r != THRESH) begin
      lowCnt_r <= lowCnt_r + 1'b1;
    end
  end

  // short glitches rejected
  // threshold sits between reject and accept widths
  always_ff @(posedge clk) begin
    if (srst) begin
      pdnActive <= 1'b0;
    end else begin
      pdnActive <= !pinLevel && (lowCnt_r >= THRESH - 1'b1);
    end
  end
endmodule // dms_pdn_filter
`default_nettype wire

// ---- test/dms_top_chk.sv ----
`default_nettype none
module dms_top_chk
  import dms_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic              regWe,
  input wire logic              regRe,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic              powerDownPinN,
  input wire logic              coreRun,
  input wire logic              dsdActive,
  input wire logic [2:0]        speedEff,
  input wire logic              ratioOk,
  input wire logic              dataBitClock,
  input wire logic              dataFrame,
  input wire logic              dataLeft,
  input wire logic              dataRight
);
  timeunit 1ns;
  timeprecision 100ps;
  // three saturated frame ticks plus sync slack
  localparam int CHG_LIMIT = 13000;
  logic        auto_r;
  logic        run_r;
  logic [2:0]  spdExp_r;
  logic [13:0] lowCnt_r;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // shadow of the control bits; any low level on the pin restores the defaults
  always_ff @(posedge clk) begin
    if (srst || !powerDownPinN) begin
      auto_r <= 1'b0;
      run_r  <= 1'b1;
    end else if (regWe && regAddr == ADDR_CTRL) begin
      auto_r <= regWdata[CTRL_AUTO_BIT];
      run_r  <= regWdata[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (regWe && regAddr == ADDR_SPEED) begin
      if (regWdata[2:0] == 3'h3) begin
        spdExp_r <= speedEff;
      end else begin
        spdExp_r <= regWdata[2] ? {2'b10, regWdata[0]} : regWdata[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || coreRun || !run_r || !powerDownPinN) begin
      lowCnt_r <= 14'h0000;
    end else begin
      lowCnt_r <= lowCnt_r + 14'h0001;
    end
  end

  a_read_idle: assert property (!$past(regRe) |-> regRdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_status_read: assert property ($past(regRe) && $past(regAddr) == ADDR_STATUS
    |-> regRdata[6:4] == $past(speedEff) && regRdata[1] == $past(dsdActive))
    else $error("status read does not match outputs");
  a_idle_quiet: assert property (!coreRun && !$past(coreRun) |->
    {dataBitClock, dataFrame, dataLeft, dataRight} == 4'h0)
    else $error("data outputs active while stopped");
  a_pcm_right: assert property (!dsdActive && !$past(dsdActive) |-> !dataRight)
    else $error("right data active in pcm");
  a_dsd_frame: assert property (dsdActive && $past(dsdActive) |-> !dataFrame)
    else $error("frame active in dsd");
  a_ratio_dsd: assert property (dsdActive && $past(dsdActive) |-> !ratioOk)
    else $error("ratio flag set in dsd");
  a_speed_legal: assert property (speedEff inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
    else $error("unlisted speed applied");
  a_speed_map: assert property (regWe && regAddr == ADDR_SPEED && !auto_r
    |-> ##[1:2] speedEff == spdExp_r)
    else $error("speed code not applied as decoded");
  a_run_drop: assert property (regWe && regAddr == ADDR_CTRL &&
    !regWdata[CTRL_RUN_BIT] |-> ##[1:2] !coreRun)
    else $error("core still running after soft reset");
  a_chg_bound: assert property (lowCnt_r < CHG_LIMIT)
    else $error("changeover took too long");

  c_run: cover property ($rose(coreRun));
  c_dsd: cover property ($rose(dsdActive));
  c_ratio: cover property ($rose(ratioOk));
endmodule // dms_top_chk

bind dms_top dms_top_chk dms_top_chk_i (.clk, .srst, .regAddr, .regWdata, .regWe, .regRe,
  .regRdata, .powerDownPinN, .coreRun, .dsdActive, .speedEff, .ratioOk, .dataBitClock,
  .dataFrame, .dataLeft, .dataRight);
`default_nettype wire

// ---- test/dms_source_model.sv ----
`default_nettype none
module dms_source_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [11:0] framePeriod,
  output var  logic        frameClock,
  output var  logic        serialBitClock,
  output var  logic        serialAudioIn,
  output var  logic        dsdBitClock,
  output var  logic        dsdLeftIn,
  output var  logic        dsdRightIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] cnt_r;

  always_ff @(posedge clk) begin
    // reset keeps the counter out of an unknown start
    if (srst || framePeriod == 12'h000 || cnt_r >= framePeriod - 12'h001) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  // zero period: frame clock stands still
  assign frameClock     = (framePeriod != 12'h000) && (cnt_r < {1'b0, framePeriod[11:1]});
  assign serialBitClock = cnt_r[1];
  assign dsdBitClock    = cnt_r[2];
  // distinct static levels make the routing visible
  assign serialAudioIn  = 1'b1;
  assign dsdLeftIn      = 1'b0;
  assign dsdRightIn     = 1'b1;
endmodule // dms_source_model
`default_nettype wire

// ---- test/dms_top_tb.sv ----
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module dms_top_tb
  import dms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, srst, regWe, regRe, powerDownPinN, parallelMode;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata;
  logic        sbc, frm, sdi, dbc, dsl, dsr;
  logic        coreRun, dsdActive, ratioOk, dataBitClock, dataFrame, dataLeft, dataRight;
  logic [2:0]  speedEff;
  logic [11:0] framePeriod;
  int          n_fail, n_checks;

  dms_top dms_top_i (.clk, .srst, .regAddr, .regWdata, .regWe, .regRe, .regRdata,
    .powerDownPinN, .parallelMode, .serialBitClock(sbc), .frameClock(frm),
    .serialAudioIn(sdi), .dsdBitClock(dbc), .dsdLeftIn(dsl), .dsdRightIn(dsr), .coreRun,
    .dsdActive, .speedEff, .ratioOk, .dataBitClock, .dataFrame, .dataLeft, .dataRight);
  dms_source_model dms_source_model_i (.clk, .srst, .framePeriod, .frameClock(frm),
    .serialBitClock(sbc), .serialAudioIn(sdi), .dsdBitClock(dbc), .dsdLeftIn(dsl),
    .dsdRightIn(dsr));

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWe    <= 1'b1;
    @(posedge clk);
    regWe <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRe   <= 1'b1;
    @(posedge clk);
    regRe <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic waitRun(output int n);
    n = 0;
    // look only once the edge's updates have settled
    #1;
    while (coreRun !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("runWait", 1'b1, 1'(n < 20000))
  endtask

  task automatic pulse(input int n);
    @(posedge clk);
    powerDownPinN <= 1'b0;
    repeat (n) @(posedge clk);
    powerDownPinN <= 1'b1;
    repeat (40) @(posedge clk);
  endtask

  task automatic t_defaults;
    logic [7:0] d;
    rd(ADDR_CTRL, d);
    `CHK("ctrl", CTRL_RESET, d[2:0])
    rd(ADDR_STATUS, d);
    `CHK("spd", SPEED_RESET, d[6:4])
  endtask

  task automatic t_speed;
    logic [7:0] d;
    logic [2:0] ev [8] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h4, 3'h5, 3'h4, 3'h5};
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_SPEED, 8'(i));
      // soft reset after a speed change
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CTRL, 8'h01);
      rd(ADDR_STATUS, d);
      `CHK("spd", ev[i], d[6:4])
    end
  endtask

  task automatic t_ratio;
    logic [7:0]  d;
    logic [11:0] pv [10] = '{12'h040, 12'h041, 12'h200, 12'h0ff, 12'h480, 12'h201, 12'h0c0,
                             12'h0c8, 12'h020, 12'h081};
    logic [2:0]  cv [10] = '{3'h5, 3'h5, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    logic        ev [10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 10; i++) begin
      framePeriod <= pv[i];
      wr(ADDR_SPEED, {5'h00, cv[i]});
      repeat (3 * pv[i] + 20) @(posedge clk);
      #1;
      `CHK("ratioOk", ev[i], ratioOk)
      rd(ADDR_RATIO_LO, d);
      `CHK("ratioLo", pv[i][7:0], d)
      rd(ADDR_RATIO_HI, d);
      `CHK("ratioHi", {4'h0, pv[i][11:8]}, d)
    end
  endtask

  task automatic t_auto;
    logic [7:0] d;
    framePeriod <= 12'h0c8;
    wr(ADDR_CTRL, 8'h03);
    repeat (700) @(posedge clk);
    wr(ADDR_SPEED, 8'h00);
    rd(ADDR_STATUS, d);
    `CHK("autoSpd", 4'b0101, {d[6:4], d[STAT_AUTO_BIT]})
    framePeriod <= 12'h258;
    repeat (1900) @(posedge clk);
    rd(ADDR_STATUS, d);
    `CHK("autoNorm", 3'h0, d[6:4])
    wr(ADDR_CTRL, 8'h01);
  endtask

  task automatic t_dsd(input logic par);
    int   n;
    logic b;
    framePeriod <= 12'h040;
    @(posedge clk);
    parallelMode <= par;
    // the sample tick must settle to the new frame period first
    repeat (800) @(posedge clk);
    wr(ADDR_CTRL, 8'h04);
    // soft reset follows the interface change
    wr(ADDR_CTRL, 8'h05);
    waitRun(n);
    repeat (8) @(posedge clk);
    #1;
    if (par) begin
      `CHK("parPcm", 2'b10, {dataLeft, dsdActive})
    end else begin
      `CHK("chgTime", 1'b1, 1'(n >= 128 && n <= 200))
      `CHK("dsdPins", 4'b1001, {dsdActive, dataFrame, dataLeft, dataRight})
      b = dataBitClock;
      repeat (4) @(posedge clk);
      #1;
      `CHK("dsdBck", ~b, dataBitClock)
    end
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    waitRun(n);
    @(posedge clk);
    parallelMode <= 1'b0;
    repeat (7) @(posedge clk);
    #1;
    `CHK("pcmPins", 3'b010, {dsdActive, dataLeft, dataRight})
    b = dataBitClock;
    repeat (2) @(posedge clk);
    #1;
    `CHK("pcmBck", ~b, dataBitClock)
  endtask

  task automatic t_pdn;
    logic [7:0] d;
    wr(ADDR_SPEED, 8'h01);
    pulse(6);
    rd(ADDR_SPEED, d);
    `CHK("pdShort", 3'h1, d[2:0])
    pulse(30);
    rd(ADDR_SPEED, d);
    `CHK("pdLong", 3'h0, d[2:0])
    rd(ADDR_CTRL, d);
    `CHK("pdCtrl", 3'h1, d[2:0])
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole sequence needs about 20k cycles
  initial begin
    #(40000 * 5);
    n_fail++;
    conclude;
  end

  initial begin
    int n;
    srst          = 1'b1;
    regAddr       = 4'h0;
    regWdata      = 8'h00;
    regWe         = 1'b0;
    regRe         = 1'b0;
    powerDownPinN = 1'b1;
    parallelMode  = 1'b0;
    framePeriod   = 12'd64;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_defaults;
    waitRun(n);
    t_speed;
    t_ratio;
    t_auto;
    t_dsd(1'b0);
    t_dsd(1'b1);
    t_pdn;
    conclude;
  end
endmodule // dms_top_tb
`default_nettype wire
